/* rtl/pac_device.sv */
// Converter end: strobe decode, channel latch, busy and result bus
// *****************************************************************
// What this block does
// - Drive data only under chip select and read
// - Strobes count only with chip select low
// - Chip select plus write starts conversion
// - Conversion start floats the data outputs
// - Write cycle picks next sampled channel
// - Busy low for whole conversion
// - Busy rises at finish, enabling reads
// - Each sample lasts sixteen enabled clock periods
// - Address latched on read or write rise
// - Address code high-low selects inputs zero-three
// - Data line zero carries result LSB
// *****************************************************************
`include "pac_defs.svh"
module pac_device #(
  parameter int CONV_CYCLES = `PAC_CONV_CYCLES
) (
  // Clock, enable and reset
  input  wire logic                   clock,
  input  wire logic                   clk_en,
  input  wire logic                   rst_n,
  // Host bus
  pac_if.device                       bus,
  // Analog core side: sampled channel and finished result
  input  wire logic [`PAC_DATA_W-1:0] core_result,
  output logic      [`PAC_ADDR_W-1:0] sample_chan,
  output logic                        sample_start
);

  // *****************************************************************
  // Pin synchronisers
  // *****************************************************************
  logic [4:0] meta_q;   // First stage, read by sync_q only
  logic [4:0] sync_q;   // {cs_n, wr_n, rd_n, hi, lo} safe copies
  logic       cs_n_q;   // Previous synced chip select
  logic       wr_n_q;   // Previous synced write strobe
  logic       rd_n_q;   // Previous synced read strobe

  // Two flops on each host pin; strobes idle high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 5'h1C;
      sync_q <= 5'h1C;
    end else if (clk_en) begin
      meta_q <= {bus.cs_n, bus.wr_n, bus.rd_n,
                 bus.chan_addr_hi, bus.chan_addr_lo};
      sync_q <= meta_q;
    end
  end

  // Strobe and select history for edge detection; select is kept too
  // because hosts often lift select in the same cycle as a strobe, and
  // the rise must still count as a selected one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else if (clk_en) begin
      cs_n_q <= sync_q[4];
      wr_n_q <= sync_q[3];
      rd_n_q <= sync_q[2];
    end
  end

  // *****************************************************************
  // Strobe decode
  // *****************************************************************
  logic cs_act;      // Chip select held low
  logic wr_fall;     // Write strobe just went low under select
  logic wr_rise;     // Write strobe rising edge under select
  logic rd_rise;     // Read strobe rising edge under select
  logic rd_qual;     // Qualified read in progress

  // A strobe rise counts when select was low while the strobe was
  // still low; testing select at the rise itself would miss every
  // cycle in which the host lifts select and strobe together, and
  // the channel would then never be latched
  function automatic logic strobe_rose(input logic sel_n_was,
                                       input logic stb_n_now,
                                       input logic stb_n_was);
    strobe_rose = !sel_n_was && stb_n_now && !stb_n_was;
  endfunction

  assign cs_act  = !sync_q[4];
  assign wr_fall = cs_act && !sync_q[3] && wr_n_q;
  assign wr_rise = strobe_rose(cs_n_q, sync_q[3], wr_n_q);
  assign rd_rise = strobe_rose(cs_n_q, sync_q[2], rd_n_q);
  assign rd_qual = cs_act && !sync_q[2];

  // *****************************************************************
  // Channel address latch
  // *****************************************************************
  logic [`PAC_ADDR_W-1:0] chan_q;   // Channel for the next sample

  // High pin is the MSB, so code 2 is input two
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= `PAC_CH0;
    end else if (clk_en && (wr_rise || rd_rise)) begin
      chan_q <= sync_q[1:0];
    end
  end

  // *****************************************************************
  // Conversion sequencer
  // *****************************************************************
  pac_pkg::pac_dev_state_e state_q;
  logic [`PAC_CNT_W-1:0]   cnt_q;    // Clock periods spent converting
  logic                    last_cyc; // Final period of the sample
  logic                    conv_end; // Final period of a running sample

  assign last_cyc = (cnt_q == `PAC_CNT_W'(CONV_CYCLES - 1));
  // One decode shared by busy and result capture; the two agree on the cycle in
  // which a sample ends, except when a new write falls in it and keeps busy low
  assign conv_end = (state_q == pac_pkg::PAC_CONV) && last_cyc;

  // A new write restarts even a running conversion, as on the pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pac_pkg::PAC_IDLE;
      cnt_q   <= '0;
    end else if (clk_en) begin
      if (wr_fall) begin
        state_q <= pac_pkg::PAC_CONV;
        cnt_q   <= '0;
      end else begin
        case (state_q)
          pac_pkg::PAC_IDLE: begin
            cnt_q <= '0;
          end
          pac_pkg::PAC_CONV: begin
            if (last_cyc) begin
              state_q <= pac_pkg::PAC_IDLE;
            end else begin
              cnt_q <= cnt_q + `PAC_CNT_W'(1);
            end
          end
          default: begin
            state_q <= pac_pkg::PAC_IDLE;
          end
        endcase
      end
    end
  end

  // Sample channel: the one latched before this write started
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_chan  <= `PAC_CH0;
      sample_start <= 1'b0;
    end else if (clk_en) begin
      sample_start <= wr_fall;
      if (wr_fall) begin
        sample_chan <= chan_q;
      end
    end
  end

  // Busy low from start to finish, then high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.busy_n <= 1'b1;
    end else if (clk_en) begin
      if (wr_fall) begin
        bus.busy_n <= 1'b0;
      end else if (conv_end) begin
        bus.busy_n <= 1'b1;
      end
    end
  end

  // *****************************************************************
  // Result register and output bus
  // *****************************************************************
  logic [`PAC_DATA_W-1:0] result_q;   // Last finished conversion

  // Result taken as busy rises; bit 0 is the LSB
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (clk_en && conv_end) begin
      result_q <= core_result;
    end
  end

  // Drivers on only for a qualified read while not converting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.data_oe  <= 1'b0;
      bus.data_out <= '0;
    end else if (clk_en) begin
      if (wr_fall || state_q == pac_pkg::PAC_CONV) begin
        bus.data_oe <= 1'b0;
      end else begin
        bus.data_oe <= rd_qual;
      end
      // Data follows the result always; the enable alone gates the pins,
      // so the word is already settled when the drivers turn on
      bus.data_out <= result_q;
    end
  end

endmodule

/* rtl/pac_defs.svh */
// Constants shared by both ends of the converter control link
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH

// Result width and channel address width
`define PAC_DATA_W      12
`define PAC_ADDR_W      2
// Clock periods per sample, and the counter width that holds them
`define PAC_CONV_CYCLES 16
`define PAC_CNT_W       5
// Channel codes, high bit then low bit
`define PAC_CH0         2'h0
`define PAC_CH1         2'h1
`define PAC_CH2         2'h2
`define PAC_CH3         2'h3
// Host write strobe width in clock cycles, minus one
`define PAC_STROBE_CYC  3'h2
// Host settle count before it first looks at busy, minus one
`define PAC_SETTLE_CYC  3'h7

`endif

/* rtl/pac_pkg.sv */
// Types shared by both ends of the converter control link
package pac_pkg;
  // Device conversion state
  typedef enum logic [0:0] {
    PAC_IDLE = 1'b0,
    PAC_CONV = 1'b1
  } pac_dev_state_e;
  // Host bus cycle state
  typedef enum logic [2:0] {
    PAC_H_IDLE  = 3'b000,
    PAC_H_WRITE = 3'b001,
    PAC_H_WAIT  = 3'b010,
    PAC_H_READ  = 3'b011,
    PAC_H_GAP   = 3'b100
  } pac_host_state_e;
endpackage

/* rtl/pac_if.sv */
// Parallel host bus joining host and converter control
`include "pac_defs.svh"
interface pac_if;
  // Host-driven strobes, all active low
  logic                    cs_n;
  logic                    wr_n;
  logic                    rd_n;
  // Channel address pins
  logic                    chan_addr_hi;
  logic                    chan_addr_lo;
  // Conversion status, low while converting
  logic                    busy_n;
  // Tri-state result bus as output, enable and resolved level
  logic [`PAC_DATA_W-1:0]  data_out;
  logic                    data_oe;
  logic [`PAC_DATA_W-1:0]  data_in;

  // Resolved bus: undriven lines read as zero in this model
  assign data_in = data_oe ? data_out : '0;

  // Converter end
  modport device (
    input  cs_n, wr_n, rd_n, chan_addr_hi, chan_addr_lo,
    output busy_n, data_out, data_oe
  );
  // Host end
  modport host (
    output cs_n, wr_n, rd_n, chan_addr_hi, chan_addr_lo,
    input  busy_n, data_in, data_oe
  );
endinterface

/* rtl/pac_host.sv */
// Host end: runs write, wait on busy, read cycles on request
`include "pac_defs.svh"
module pac_host (
  // Clock, enable and reset
  input  wire logic                   clock,
  input  wire logic                   clk_en,
  input  wire logic                   rst_n,
  // Host bus
  pac_if.host                         bus,
  // User side: request a sample of a channel, get the result
  input  wire logic                   req_valid,
  input  wire logic [`PAC_ADDR_W-1:0] req_chan,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic      [`PAC_DATA_W-1:0] rsp_data
);

  // *****************************************************************
  // Synchronisers for device outputs
  // *****************************************************************
  logic busy_meta_q;   // First stage only
  logic busy_sync_q;   // Safe busy level

  // Busy idles high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_meta_q <= 1'b1;
      busy_sync_q <= 1'b1;
    end else if (clk_en) begin
      busy_meta_q <= bus.busy_n;
      busy_sync_q <= busy_meta_q;
    end
  end

  // *****************************************************************
  // Bus cycle sequencer
  // *****************************************************************
  pac_pkg::pac_host_state_e state_q;
  logic [2:0]               tmr_q;   // Strobe and settle timer

  // Write with channel, wait past busy low then high, then read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= pac_pkg::PAC_H_IDLE;
      tmr_q            <= '0;
      bus.cs_n         <= 1'b1;
      bus.wr_n         <= 1'b1;
      bus.rd_n         <= 1'b1;
      bus.chan_addr_hi <= 1'b0;
      bus.chan_addr_lo <= 1'b0;
      req_ready        <= 1'b1;
      rsp_valid        <= 1'b0;
      rsp_data         <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      case (state_q)
        pac_pkg::PAC_H_IDLE: begin
          if (req_valid) begin
            // Address stays steady through the write rising edge
            bus.chan_addr_hi <= req_chan[1];
            bus.chan_addr_lo <= req_chan[0];
            bus.cs_n         <= 1'b0;
            bus.wr_n         <= 1'b0;
            req_ready        <= 1'b0;
            tmr_q            <= '0;
            state_q          <= pac_pkg::PAC_H_WRITE;
          end
        end
        pac_pkg::PAC_H_WRITE: begin
          tmr_q <= tmr_q + 3'h1;
          if (tmr_q == `PAC_STROBE_CYC) begin
            bus.wr_n <= 1'b1;
            bus.cs_n <= 1'b1;
            tmr_q    <= '0;
            state_q  <= pac_pkg::PAC_H_WAIT;
          end
        end
        pac_pkg::PAC_H_WAIT: begin
          // Settle time lets busy fall through the synchroniser
          if (tmr_q != `PAC_SETTLE_CYC) begin
            tmr_q <= tmr_q + 3'h1;
          end else if (busy_sync_q) begin
            bus.cs_n <= 1'b0;
            bus.rd_n <= 1'b0;
            tmr_q    <= '0;
            state_q  <= pac_pkg::PAC_H_READ;
          end
        end
        pac_pkg::PAC_H_READ: begin
          tmr_q <= tmr_q + 3'h1;
          if (tmr_q == `PAC_STROBE_CYC + 3'h2) begin
            rsp_data  <= bus.data_in;
            rsp_valid <= 1'b1;
            bus.rd_n  <= 1'b1;
            bus.cs_n  <= 1'b1;
            tmr_q     <= '0;
            state_q   <= pac_pkg::PAC_H_GAP;
          end
        end
        pac_pkg::PAC_H_GAP: begin
          // Lets the device see strobes high before the next cycle
          tmr_q <= tmr_q + 3'h1;
          if (tmr_q == `PAC_STROBE_CYC) begin
            req_ready <= 1'b1;
            state_q   <= pac_pkg::PAC_H_IDLE;
          end
        end
        default: begin
          state_q <= pac_pkg::PAC_H_IDLE;
        end
      endcase
    end
  end

endmodule

/* tb/pac_checker.sv */
// Concurrent checks on the host bus between host and converter
// ******************************************************
// Bus checker
// ******************************************************
module pac_checker #(
  parameter int CONV_CYCLES = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host strobes and channel address
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic chan_addr_hi,
  input wire logic chan_addr_lo,
  // Device answers
  input wire logic busy_n,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Busy-low cycle count; a counter avoids a long repetition
  logic [7:0] low_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 8'h00;
    end else begin
      low_q <= busy_n ? 8'h00 : low_q + 8'h01;
    end
  end

  // Write strobe newly low under chip select
  sequence s_wr_start;
    !cs_n && !wr_n && $past(wr_n);
  endsequence
  // Qualified read held while idle
  sequence s_rd_held;
    (busy_n && !cs_n && !rd_n) [*4];
  endsequence

  property p_start;
    s_wr_start |-> ##3 !busy_n;
  endproperty
  a_start: assert property (p_start)
    else $error("busy did not fall after a write");
  property p_fall_cause;
    $fell(busy_n) |-> $past(!cs_n && !wr_n, 3);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("busy fell without a qualified write");
  property p_conv_len;
    $rose(busy_n) |-> low_q == CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_float_conv;
    !busy_n |-> !data_oe;
  endproperty
  a_float_conv: assert property (p_float_conv)
    else $error("bus driven during conversion");
  property p_oe_cause;
    data_oe |-> $past(!cs_n && !rd_n, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without a qualified read");
  property p_read_on;
    s_rd_held |-> data_oe;
  endproperty
  a_read_on: assert property (p_read_on)
    else $error("read after busy high not driven");
  property p_read_off;
    $rose(rd_n) |-> ##3 !data_oe;
  endproperty
  a_read_off: assert property (p_read_off)
    else $error("bus still driven after read end");
  property p_rd_waits;
    $fell(rd_n) && !cs_n |-> busy_n;
  endproperty
  a_rd_waits: assert property (p_rd_waits)
    else $error("read started during conversion");
  property p_addr_hold;
    !wr_n && $past(!wr_n) |-> $stable({chan_addr_hi, chan_addr_lo});
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during write");
endmodule

/* tb/test_parallel_adc_conversion_control.sv */
// Bench: host and converter ends joined, plus a bench-driven converter
`include "pac_defs.svh"
module test_parallel_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: requested channel, result, channel expected to be sampled
  typedef struct {
    logic [1:0]  ch;
    logic [11:0] res;
    logic [1:0]  smp;
  } pac_row_s;
  // ******************************************************
  // Signals
  // ******************************************************
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  req_chan = 2'h0;
  logic        req_ready, rsp_valid, start_m, start_b;
  logic [11:0] rsp_data, core_m = 12'h000, core_b = 12'hC35, d;
  logic [1:0]  chan_m, chan_b, seen_b;
  logic        oe;
  logic        en_b = 1'b1;   // Clock enable of the second converter
  int          failures = 0, checks = 0, cyc = 0, low_b = 0, n;
  // Sampled channel lags one request behind the address, by latching
  pac_row_s rows [5] = '{'{2'h1, 12'h001, 2'h0}, '{2'h2, 12'h800, 2'h1},
    '{2'h3, 12'hA5C, 2'h2}, '{2'h0, 12'h3FF, 2'h3},
    '{2'h2, 12'h5A3, 2'h0}};
  pac_if bus ();
  pac_if bus_b ();
  pac_device pac_device_i (.clock, .clk_en(1'b1), .rst_n, .bus(bus),
    .core_result(core_m), .sample_chan(chan_m), .sample_start(start_m));
  pac_host pac_host_i (.clock, .clk_en(1'b1), .rst_n, .bus(bus),
    .req_valid, .req_chan, .req_ready, .rsp_valid, .rsp_data);
  // Second converter, its host pins driven by the bench to break rules
  pac_device pac_device_i2 (.clock, .clk_en(en_b), .rst_n, .bus(bus_b),
    .core_result(core_b), .sample_chan(chan_b), .sample_start(start_b));
  pac_checker pac_checker_i (.clock, .rst_n, .cs_n(bus.cs_n),
    .wr_n(bus.wr_n), .rd_n(bus.rd_n), .chan_addr_hi(bus.chan_addr_hi),
    .chan_addr_lo(bus.chan_addr_lo), .busy_n(bus.busy_n),
    .data_oe(bus.data_oe));
  always #20 clock = ~clock;
  // Watchers on the second converter: busy-low cycles, sampled channel
  always @(negedge clock) begin
    if (bus_b.busy_n === 1'b0) low_b++;
    if (start_b === 1'b1) seen_b = chan_b;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // One strobe cycle on the second bus, sampling the bus before release
  task automatic b_cycle(input bit wr, input logic [1:0] ch,
                         input logic cs_v);
    @(negedge clock);
    bus_b.cs_n = cs_v;
    {bus_b.chan_addr_hi, bus_b.chan_addr_lo} = ch;
    if (wr) bus_b.wr_n = 1'b0;
    else bus_b.rd_n = 1'b0;
    repeat (4) @(negedge clock);
    oe = bus_b.data_oe;
    d = bus_b.data_in;
    {bus_b.cs_n, bus_b.wr_n, bus_b.rd_n} = 3'h7;
    repeat (3) @(negedge clock);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {bus_b.cs_n, bus_b.wr_n, bus_b.rd_n} = 3'h7;
    {bus_b.chan_addr_hi, bus_b.chan_addr_lo} = 2'h0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(bus.busy_n === 1'b1 && bus.data_oe === 1'b0, "reset bus");
    chk(req_ready === 1'b1 && rsp_data === 12'h000, "reset host");
    $display("reset test done");
    // Ordinary samples through both ends, every channel code
    foreach (rows[r]) begin
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clock);
      req_chan = rows[r].ch;
      core_m = rows[r].res;
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      for (n = 0; n < 40 && start_m !== 1'b1; n++) @(negedge clock);
      chk(start_m === 1'b1 && chan_m === rows[r].smp, "channel");
      for (n = 0; n < 60 && rsp_valid !== 1'b1; n++) @(negedge clock);
      chk(rsp_valid === 1'b1 && rsp_data === rows[r].res, "result");
    end
    $display("row test done");
    // Read rise latches address 3; the next write samples it
    b_cycle(1'b0, 2'h3, 1'b0);
    low_b = 0;
    b_cycle(1'b1, 2'h1, 1'b0);
    chk(seen_b === 2'h3, "read edge latch");
    // Read during conversion is refused and floats
    b_cycle(1'b0, 2'h1, 1'b0);
    chk(oe === 1'b0 && d === 12'h000, "read in conversion");
    for (n = 0; n < 40 && bus_b.busy_n !== 1'b1; n++) @(negedge clock);
    chk(low_b == `PAC_CONV_CYCLES, "busy low length");
    b_cycle(1'b0, 2'h1, 1'b0);
    chk(oe === 1'b1 && d === core_b, "read after busy");
    // Strobes with chip select high do nothing
    b_cycle(1'b1, 2'h2, 1'b1);
    chk(bus_b.busy_n === 1'b1, "write without select");
    b_cycle(1'b0, 2'h2, 1'b1);
    chk(oe === 1'b0 && d === 12'h000, "read without select");
    // A low clock enable freezes the count: five frozen cycles add five
    low_b = 0;
    b_cycle(1'b1, 2'h0, 1'b0);
    en_b = 1'b0;
    repeat (5) @(negedge clock);
    en_b = 1'b1;
    for (n = 0; n < 40 && bus_b.busy_n !== 1'b1; n++) @(negedge clock);
    chk(low_b == `PAC_CONV_CYCLES + 5, "enable freeze");
    $display("second bus test done");
    tally_and_finish();
  end
endmodule
